// ==== logic/flash_prog_cfg.svh ====
// Functional notes
// - First set up the serial channel, then clear write protection with opcode 01.
// - Copy 8 KB loader from RAM FFF80000 to flash address 0.
// - Copy application to flash 2000; source and length come from its descriptor.
// - Check each destination range is blank; erase only when not, never program dirty.
// - Program one byte per command using opcode 02.
// - Erase whole 64 KB blocks with opcode D8, covering every touched block.
// - Send write enable opcode 06 before every program, erase or status write.
// - Use opcode 04 to disable writing when finished.
// - Read the flash status register with opcode 05.
// - All flash traffic goes over serial channel zero only.
// - Descriptor holds start and end pointers; length is end minus start.
`ifndef FLASH_PROG_CFG_SVH
`define FLASH_PROG_CFG_SVH
`define OP_WRSR      8'h01
`define OP_PROG      8'h02
`define OP_WRDI      8'h04
`define OP_RDSR      8'h05
`define OP_WREN      8'h06
`define OP_ERASE     8'hD8
`define OP_READ_DFLT 8'h03
`define WRSR_VALUE   8'h00
`define WIP_BIT      0
`define LDR_SRC      32'hFFF8_0000
`define LDR_DST      32'h0000_0000
`define LDR_LEN      32'h0000_2000
`define APP_DST      32'h0000_2000
`define HDR_BYTES    32'h0000_0004
`define DESC_BYTES   3'h7
`endif

// ==== logic/flash_prog_pkg.sv ====
package flash_prog_pkg;
  typedef enum logic [4:0] {
    S_IDLE, S_WRSR_EN, S_WRSR, S_DESC, S_DWAIT, S_CHECK, S_CHKEND,
    S_ERASE, S_ERASE2, S_ERNEXT, S_NEXT, S_PSTART, S_FETCH, S_FWAIT,
    S_PWREN, S_PCMD, S_PNEXT, S_POLL, S_PCHK, S_WRDI, S_XFER, S_DONE
  } state_type;
endpackage

// ==== logic/serial_flash_image_programmer.sv ====
`timescale 1ns/1ns
`include "flash_prog_cfg.svh"

module serial_flash_image_programmer #(
  parameter logic [7:0] READ_OPCODE = `OP_READ_DFLT
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [31:0] desc_addr,
  output logic      [31:0] ram_addr,
  output logic             ram_rd,
  input  wire logic [7:0]  ram_rdata,
  output logic             spi_sclk,
  output logic             spi_cs_b,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  output logic             busy,
  output logic             done
);

  flash_prog_pkg::state_type state_q;
  flash_prog_pkg::state_type ret_q;
  flash_prog_pkg::state_type poll_ret_q;

  logic [31:0] k_q;
  logic [31:0] n_q;
  logic [7:0]  fr_op_q;
  logic [23:0] fr_addr_q;
  logic [7:0]  fr_dat_q;
  logic        wait_q;
  logic        launch_q;
  logic [7:0]  tx_q;
  logic [7:0]  last_rx_q;
  logic        dirty_q;
  logic        checking_q;
  logic [63:0] desc_q;
  logic [2:0]  di_q;
  logic        img_q;
  logic        prog_phase_q;
  logic [7:0]  blk_q;
  logic [31:0] off_q;

  logic [7:0]  sh_q;
  logic [2:0]  bits_q;
  logic        sh_busy_q;
  logic        byte_done_q;
  logic [7:0]  rx_q;

  logic [31:0] img_src;
  logic [31:0] img_dst;
  logic [31:0] img_len;
  logic [31:0] img_last;
  logic [7:0]  tx_byte;

  // The loader image is fixed; the application comes from the descriptor.
  always_comb begin
    if (!img_q) begin
      img_src = `LDR_SRC;
      img_dst = `LDR_DST;
      img_len = `LDR_LEN;
    end else begin
      img_src = desc_q[63:32];
      img_dst = `APP_DST;
      img_len = desc_q[31:0] - desc_q[63:32];
    end
    img_last = img_dst + img_len - 32'h0000_0001;
  end

  // Byte order within a frame: opcode, address high to low, then data.
  always_comb begin
    if (k_q == 32'h0000_0000) begin
      tx_byte = fr_op_q;
    end else if (k_q == 32'h0000_0001) begin
      tx_byte = fr_addr_q[23:16];
    end else if (k_q == 32'h0000_0002) begin
      tx_byte = fr_addr_q[15:8];
    end else if (k_q == 32'h0000_0003) begin
      tx_byte = fr_addr_q[7:0];
    end else begin
      tx_byte = fr_dat_q;
    end
  end

  task automatic go(input logic [7:0] op, input logic [23:0] addr,
                    input logic [31:0] n, input flash_prog_pkg::state_type r);
    fr_op_q   <= op;
    fr_addr_q <= addr;
    n_q       <= n;
    k_q       <= 32'h0000_0000;
    spi_cs_b  <= 1'b0;
    ret_q     <= r;
    state_q   <= flash_prog_pkg::S_XFER;
  endtask

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= flash_prog_pkg::S_IDLE;
      ret_q        <= flash_prog_pkg::S_IDLE;
      poll_ret_q   <= flash_prog_pkg::S_IDLE;
      k_q          <= 32'h0000_0000;
      n_q          <= 32'h0000_0000;
      fr_op_q      <= 8'h00;
      fr_addr_q    <= 24'h000000;
      fr_dat_q     <= 8'h00;
      wait_q       <= 1'b0;
      launch_q     <= 1'b0;
      tx_q         <= 8'h00;
      last_rx_q    <= 8'h00;
      dirty_q      <= 1'b0;
      checking_q   <= 1'b0;
      desc_q       <= 64'h0000_0000_0000_0000;
      di_q         <= 3'h0;
      img_q        <= 1'b0;
      prog_phase_q <= 1'b0;
      blk_q        <= 8'h00;
      off_q        <= 32'h0000_0000;
      ram_addr     <= 32'h0000_0000;
      ram_rd       <= 1'b0;
      spi_cs_b     <= 1'b1;
      busy         <= 1'b0;
      done         <= 1'b0;
    end else begin
      launch_q <= 1'b0;
      ram_rd   <= 1'b0;
      done     <= 1'b0;
      unique case (state_q)
        flash_prog_pkg::S_IDLE: begin
          if (start) begin
            busy         <= 1'b1;
            img_q        <= 1'b0;
            prog_phase_q <= 1'b0;
            go(`OP_WREN, 24'h000000, 32'h0000_0001, flash_prog_pkg::S_WRSR);
          end
        end
        flash_prog_pkg::S_WRSR: begin
          fr_dat_q   <= `WRSR_VALUE;
          poll_ret_q <= flash_prog_pkg::S_DESC;
          di_q       <= 3'h0;
          // The address bytes are skipped for a two-byte frame via k offset.
          go(`OP_WRSR, 24'h000000, 32'h0000_0005, flash_prog_pkg::S_POLL);
          k_q <= 32'h0000_0003;
        end
        flash_prog_pkg::S_DESC: begin
          ram_rd   <= 1'b1;
          ram_addr <= desc_addr + {29'h0, di_q};
          state_q  <= flash_prog_pkg::S_DWAIT;
        end
        flash_prog_pkg::S_DWAIT: begin
          desc_q <= {desc_q[55:0], ram_rdata};
          di_q   <= di_q + 3'h1;
          if (di_q == `DESC_BYTES) begin
            state_q <= flash_prog_pkg::S_CHECK;
          end else begin
            state_q <= flash_prog_pkg::S_DESC;
          end
        end
        flash_prog_pkg::S_CHECK: begin
          dirty_q <= 1'b0;
          if (img_len == 32'h0000_0000) begin
            state_q <= flash_prog_pkg::S_NEXT;
          end else begin
            checking_q <= 1'b1;
            go(READ_OPCODE, img_dst[23:0], img_len + `HDR_BYTES,
               flash_prog_pkg::S_CHKEND);
          end
        end
        flash_prog_pkg::S_CHKEND: begin
          checking_q <= 1'b0;
          blk_q      <= img_dst[23:16];
          if (dirty_q) begin
            state_q <= flash_prog_pkg::S_ERASE;
          end else begin
            state_q <= flash_prog_pkg::S_NEXT;
          end
        end
        flash_prog_pkg::S_ERASE: begin
          go(`OP_WREN, 24'h000000, 32'h0000_0001, flash_prog_pkg::S_ERASE2);
        end
        flash_prog_pkg::S_ERASE2: begin
          poll_ret_q <= flash_prog_pkg::S_ERNEXT;
          go(`OP_ERASE, {blk_q, 16'h0000}, `HDR_BYTES, flash_prog_pkg::S_POLL);
        end
        flash_prog_pkg::S_ERNEXT: begin
          if (blk_q == img_last[23:16]) begin
            state_q <= flash_prog_pkg::S_NEXT;
          end else begin
            blk_q   <= blk_q + 8'h01;
            state_q <= flash_prog_pkg::S_ERASE;
          end
        end
        flash_prog_pkg::S_NEXT: begin
          // Both ranges are cleared before any byte is written, since the
          // application's first block also holds the loader.
          if (!img_q) begin
            img_q   <= 1'b1;
            state_q <= prog_phase_q ? flash_prog_pkg::S_PSTART : flash_prog_pkg::S_CHECK;
          end else if (!prog_phase_q) begin
            img_q        <= 1'b0;
            prog_phase_q <= 1'b1;
            state_q      <= flash_prog_pkg::S_PSTART;
          end else begin
            state_q <= flash_prog_pkg::S_WRDI;
          end
        end
        flash_prog_pkg::S_PSTART: begin
          off_q <= 32'h0000_0000;
          if (img_len == 32'h0000_0000) begin
            state_q <= flash_prog_pkg::S_NEXT;
          end else begin
            state_q <= flash_prog_pkg::S_FETCH;
          end
        end
        flash_prog_pkg::S_FETCH: begin
          ram_rd   <= 1'b1;
          ram_addr <= img_src + off_q;
          state_q  <= flash_prog_pkg::S_FWAIT;
        end
        flash_prog_pkg::S_FWAIT: begin
          fr_dat_q <= ram_rdata;
          state_q  <= flash_prog_pkg::S_PWREN;
        end
        flash_prog_pkg::S_PWREN: begin
          go(`OP_WREN, 24'h000000, 32'h0000_0001, flash_prog_pkg::S_PCMD);
        end
        flash_prog_pkg::S_PCMD: begin
          poll_ret_q <= flash_prog_pkg::S_PNEXT;
          go(`OP_PROG, img_dst[23:0] + off_q[23:0], 32'h0000_0005,
             flash_prog_pkg::S_POLL);
        end
        flash_prog_pkg::S_PNEXT: begin
          off_q <= off_q + 32'h0000_0001;
          if (off_q + 32'h0000_0001 == img_len) begin
            state_q <= flash_prog_pkg::S_NEXT;
          end else begin
            state_q <= flash_prog_pkg::S_FETCH;
          end
        end
        flash_prog_pkg::S_POLL: begin
          go(`OP_RDSR, 24'h000000, 32'h0000_0005, flash_prog_pkg::S_PCHK);
          k_q <= 32'h0000_0003;
        end
        flash_prog_pkg::S_PCHK: begin
          if (last_rx_q[`WIP_BIT]) begin
            state_q <= flash_prog_pkg::S_POLL;
          end else begin
            state_q <= poll_ret_q;
          end
        end
        flash_prog_pkg::S_WRDI: begin
          go(`OP_WRDI, 24'h000000, 32'h0000_0001, flash_prog_pkg::S_DONE);
        end
        flash_prog_pkg::S_XFER: begin
          if (!wait_q) begin
            // A blank check ends at the first dirty byte; the range is erased anyway.
            if (k_q == n_q || (checking_q && dirty_q)) begin
              spi_cs_b <= 1'b1;
              state_q  <= ret_q;
            end else begin
              launch_q <= 1'b1;
              wait_q   <= 1'b1;
              tx_q     <= (k_q == 32'h0000_0003 && n_q != `HDR_BYTES
                           && fr_op_q != `OP_PROG && fr_op_q != READ_OPCODE)
                          ? fr_op_q : tx_byte;
            end
          end else if (byte_done_q) begin
            wait_q    <= 1'b0;
            k_q       <= k_q + 32'h0000_0001;
            last_rx_q <= rx_q;
            if (checking_q && k_q >= `HDR_BYTES && rx_q != 8'hFF) begin
              dirty_q <= 1'b1;
            end
          end
        end
        flash_prog_pkg::S_DONE: begin
          busy    <= 1'b0;
          done    <= 1'b1;
          state_q <= flash_prog_pkg::S_IDLE;
        end
        default: begin
          state_q <= flash_prog_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Channel zero shifter, mode 0: sclk runs at half of ref_clk.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q        <= 8'h00;
      bits_q      <= 3'h0;
      sh_busy_q   <= 1'b0;
      byte_done_q <= 1'b0;
      rx_q        <= 8'h00;
      spi_sclk    <= 1'b0;
      spi_mosi    <= 1'b0;
    end else begin
      byte_done_q <= 1'b0;
      if (launch_q) begin
        sh_q      <= tx_q;
        spi_mosi  <= tx_q[7];
        bits_q    <= 3'h0;
        sh_busy_q <= 1'b1;
        spi_sclk  <= 1'b0;
      end else if (sh_busy_q) begin
        if (!spi_sclk) begin
          spi_sclk <= 1'b1;
          rx_q     <= {rx_q[6:0], spi_miso};
        end else begin
          spi_sclk <= 1'b0;
          bits_q   <= bits_q + 3'h1;
          sh_q     <= {sh_q[6:0], 1'b0};
          spi_mosi <= sh_q[6];
          if (bits_q == 3'h7) begin
            sh_busy_q   <= 1'b0;
            byte_done_q <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ==== testbench/flash_prog_chk.sv ====
`timescale 1ns/1ns
module flash_prog_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_cs_b,
  input wire logic spi_mosi,
  input wire logic busy,
  input wire logic done
);
  logic        sclk_q;
  logic        ev_q;
  logic [7:0]  sh_q;
  logic [7:0]  op_q;
  logic [19:0] nb_q;
  logic [1:0]  nf_q;
  wire         rise = spi_sclk && !sclk_q;
  wire         wr_now = sh_q inside {8'h01, 8'h02, 8'hD8};
  wire         wr_prev = op_q inside {8'h01, 8'h02, 8'hD8};
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sclk_q, ev_q, sh_q, op_q, nb_q, nf_q} <= '0;
    end else begin
      sclk_q <= spi_sclk;
      ev_q   <= rise && nb_q == 20'h00007;
      nb_q   <= spi_cs_b ? 20'h00000 : nb_q + {19'h00000, rise};
      if (rise) sh_q <= {sh_q[6:0], spi_mosi};
      if (ev_q) op_q <= sh_q;
      if (!busy) nf_q <= 2'h0;
      else if (ev_q && nf_q != 2'h3) nf_q <= nf_q + 2'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_first_enable: assert property (ev_q && nf_q == 2'h0 |-> sh_q == 8'h06)
    else $error("first frame not write enable");
  a_unprotect: assert property (ev_q && nf_q == 2'h1 |-> sh_q == 8'h01)
    else $error("second frame not status write");
  a_wren_lead: assert property (ev_q && wr_now |-> op_q == 8'h06)
    else $error("write command without enable");
  a_poll_next: assert property (ev_q && wr_prev |-> sh_q == 8'h05)
    else $error("no status poll after write");
  a_wrdi_last: assert property (done |-> op_q == 8'h04)
    else $error("run not closed by disable");
  a_prog_len: assert property ($rose(spi_cs_b) && op_q == 8'h02 |-> nb_q == 20'h00028)
    else $error("program frame length");
  a_erase_len: assert property ($rose(spi_cs_b) && op_q == 8'hD8 |-> nb_q == 20'h00020)
    else $error("erase frame length");
  a_mosi_hold: assert property (spi_sclk |-> $stable(spi_mosi))
    else $error("data moved while clock high");
endmodule
bind serial_flash_image_programmer flash_prog_chk u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
  .spi_mosi(spi_mosi), .busy(busy), .done(done));

// ==== testbench/spi_flash_model.sv ====
`timescale 1ns/1ns
module spi_flash_model #(
  parameter logic [7:0] READ_OPCODE = 8'h03
) (
  input  wire logic spi_sclk,
  input  wire logic spi_cs_b,
  input  wire logic spi_mosi,
  output logic      spi_miso
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  sh = 8'h00;
  logic [7:0]  op = 8'h00;
  logic [7:0]  ob = 8'h00;
  logic [7:0]  din = 8'h00;
  logic [23:0] adr = 24'h000000;
  logic        wel = 1'b0;
  logic        wip = 1'b0;
  int          nbit = 0;
  int          nb = 0;
  int          errs = 0;
  logic [7:0]  op_log [$];
  logic [23:0] adr_log [$];
  initial begin
    spi_miso = 1'b0;
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    // One dirty byte in the loader range, so skipping the erase shows up.
    mem[5] = 8'h00;
  end
  always @(negedge spi_cs_b) begin
    nbit = 0;
    nb = 0;
  end
  always @(posedge spi_sclk) begin
    sh = {sh[6:0], spi_mosi};
    nbit++;
    if (nbit % 8 == 0) nb++;
    if (nbit == 8) op_log.push_back(sh);
    if (nbit == 8) op = sh;
    if (nbit == 8 && wip && sh != 8'h05) errs++;
    if (nbit % 8 == 0 && nb >= 2 && nb <= 4) adr = {adr[15:0], sh};
    if (nb == 5) din = sh;
  end
  always @(negedge spi_sclk) begin
    if (nbit % 8 == 0)
      ob = (op == 8'h05) ? {6'h00, wel, wip} :
           (op == READ_OPCODE && nb >= 4) ? mem[adr[15:0] + 16'(nb - 4)] : 8'h00;
    spi_miso = ob[7 - nbit % 8];
  end
  always @(posedge spi_cs_b) begin
    // Released output flips, so a stale level is never read as data.
    spi_miso = ~spi_miso;
    if (nb >= 4) adr_log.push_back(adr);
    if (op == 8'h06 && nb == 1) wel = 1'b1;
    if (op == 8'h04) wel = 1'b0;
    if (op inside {8'h01, 8'h02, 8'hD8}) begin
      if (!wel) errs++;
      if (op == 8'h02 && (nb != 5 || mem[adr[15:0]] != 8'hFF)) errs++;
      if (op == 8'h02) mem[adr[15:0]] = mem[adr[15:0]] & din;
      if (op == 8'hD8 && adr[23:16] == 8'h00)
        for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
      wel = 1'b0;
      wip = 1'b1;
      // Programs finish fast and erases slowly, so both poll paths run.
      fork
        #(op == 8'h02 ? 300 : 6000) wip = 1'b0;
      join_none
    end
  end
endmodule

// ==== testbench/serial_flash_image_programmer_tb_top.sv ====
`timescale 1ns/1ns
module serial_flash_image_programmer_tb_top;
  localparam logic [63:0] desc_val = 64'h1C00_0000_1C00_0004;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        start = 1'b0;
  logic [31:0] desc_addr = 32'h0000_0100;
  logic [7:0]  ram_rdata;
  logic [31:0] ram_addr;
  logic        ram_rd;
  logic        spi_sclk;
  logic        spi_cs_b;
  logic        spi_mosi;
  logic        spi_miso;
  logic        busy;
  logic        done;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [31:0] rd_log [$];
  serial_flash_image_programmer uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .start(start), .desc_addr(desc_addr),
    .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_rdata(ram_rdata), .spi_sclk(spi_sclk),
    .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .busy(busy),
    .done(done));
  spi_flash_model u_flash (
    .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  always #50 ref_clk = ~ref_clk;
  function automatic logic [7:0] ram_byte(input logic [31:0] a);
    if (a[31:3] == 29'h0000_0020) return desc_val[63 - 8 * a[2:0] -: 8];
    return (a[31:16] == 16'hFFF8) ? a[7:0] ^ 8'hA5 : a[7:0] + 8'h30;
  endfunction
  // The sequencer takes read data at the edge that ends its strobe cycle.
  assign ram_rdata = ram_byte(ram_addr);
  // The abort scenario cuts the run short, so 20000 cycles are plenty.
  always @(posedge ref_clk) begin
    cycles++;
    if (ram_rd) rd_log.push_back(ram_addr);
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_init();
    @(posedge ref_clk) start <= 1'b1;
    @(posedge ref_clk) start <= 1'b0;
    while (u_flash.op_log.size() < 3) @(posedge ref_clk);
    check("opcode 0", 32'h06, u_flash.op_log[0]);
    check("opcode 1", 32'h01, u_flash.op_log[1]);
    check("opcode 2", 32'h05, u_flash.op_log[2]);
    check("busy", 32'h1, busy);
    $display("t_init finished");
  endtask
  task automatic t_erase();
    while (u_flash.adr_log.size() < 3) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) check("desc read", 32'h0000_0100 + i, rd_log[i]);
    check("loader check addr", 32'h0, u_flash.adr_log[0]);
    check("erase addr", 32'h0, u_flash.adr_log[1]);
    check("app check addr", 32'h2000, u_flash.adr_log[2]);
    check("dirty byte", 32'hFF, u_flash.mem[5]);
    $display("t_erase finished");
  endtask
  task automatic t_program();
    int n = 0;
    while (u_flash.adr_log.size() < 5) @(posedge ref_clk);
    foreach (u_flash.op_log[i]) if (u_flash.op_log[i] == 8'hD8) n++;
    check("erase count", 32'h1, n);
    check("prog addr 0", 32'h0, u_flash.adr_log[3]);
    check("prog addr 1", 32'h1, u_flash.adr_log[4]);
    check("loader fetch", 32'hFFF8_0000, rd_log[8]);
    check("flash byte 0", 32'hA5, u_flash.mem[0]);
    check("flash byte 1", 32'hA4, u_flash.mem[1]);
    check("model faults", 32'h0, u_flash.errs);
    $display("t_program finished");
  endtask
  task automatic t_abort();
    @(posedge ref_clk) rst_b <= 1'b0;
    @(posedge ref_clk);
    check("cs in reset", 32'h1, spi_cs_b);
    check("sclk in reset", 32'h0, spi_sclk);
    check("busy in reset", 32'h0, busy);
    @(posedge ref_clk) rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("cs after reset", 32'h1, spi_cs_b);
    $display("t_abort finished");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_init();
    t_erase();
    t_program();
    t_abort();
    conclude();
  end
endmodule
